// ---- core/bus_interface_defs.vh ----
// constants for the multiplexed dram bus interface
// assumes a single 25 MHz system clock and a synchronous active-high reset
`ifndef BUS_INTERFACE_DEFS_VH
`define BUS_INTERFACE_DEFS_VH
`define ST_IDLE 3'h0
`define ST_ROW 3'h1
`define ST_COL 3'h2
`define ST_WAIT 3'h3
`define ST_FINAL 3'h4
`define ST_HOLD 3'h5
`define ST_INTA 3'h6
`define ROW_LO 9
`define ROW_HI 17
`define MIN_WAITS 2'h2
`define POLL_PERIOD 3'h5
`define POLL_LAST 3'h4
`endif

// ---- core/ready_sync.v ----
// two-flop synchroniser for the ready input
// assumes ready may change at any time relative to clk_sys
`timescale 1ns/1ps
module ready_sync (
  input wire clk_sys, // system clock
  input wire reset, // synchronous reset
  input wire ready_in, // raw ready
  output reg ready_sync_r // synchronised ready
);
  reg ready_meta_r;
  always @(posedge clk_sys) begin
    if (reset) begin
      ready_meta_r <= 1'b1;
      ready_sync_r <= 1'b1;
    end else begin
      ready_meta_r <= ready_in;
      ready_sync_r <= ready_meta_r;
    end
  end
endmodule

// ---- core/poll_waiter.v ----
// poll instruction wait logic
// assumes poll_start is a one-cycle pulse from the sequencer
`include "bus_interface_defs.vh"
`timescale 1ns/1ps
module poll_waiter (
  input wire clk_sys, // system clock
  input wire reset, // synchronous reset
  input wire poll_start, // begin a poll instruction
  input wire poll_n, // poll pin, low = go
  input wire port1_line4_is_input, // port1 line4 in input mode
  output reg poll_busy_r, // still waiting
  output reg poll_done_r // one-cycle completion pulse
);
  reg [2:0] cnt_r;
  wire poll_low = poll_n | ~port1_line4_is_input ? ~port1_line4_is_input : 1'b1;
  always @(posedge clk_sys) begin
    if (reset) begin
      poll_busy_r <= 1'b0;
      poll_done_r <= 1'b0;
      cnt_r <= 3'h0;
    end else begin
      poll_done_r <= 1'b0;
      if (poll_start && !poll_busy_r) begin
        if (poll_low) begin
          poll_done_r <= 1'b1;
        end else begin
          poll_busy_r <= 1'b1;
          cnt_r <= 3'h0;
        end
      end else if (poll_busy_r) begin
        if (cnt_r == `POLL_LAST) begin
          cnt_r <= 3'h0;
          if (poll_low) begin
            poll_busy_r <= 1'b0;
            poll_done_r <= 1'b1;
          end
        end else begin
          cnt_r <= cnt_r + 3'h1;
        end
      end
    end
  end
endmodule

// ---- core/multiplexed_dram_bus_interface.v ----
// external bus sequencer: multiplexed address, strobes, hold, interrupt vector
// assumes the core issues one request at a time and waits for req_done_r
`include "bus_interface_defs.vh"
`timescale 1ns/1ps
module multiplexed_dram_bus_interface (
  input wire clk_sys, // system clock
  input wire reset, // synchronous reset
  input wire req_valid, // core bus request, level until accepted
  input wire req_io, // 1 = io cycle
  input wire req_write, // 1 = write
  input wire req_word, // 1 = 16-bit access
  input wire [19:0] req_addr, // byte address
  input wire [15:0] req_wdata, // write data
  output reg req_accept_r, // request taken pulse
  output reg req_done_r, // access complete pulse
  output reg [15:0] req_rdata_r, // read data
  input wire insn_last_cycle, // last clock of an instruction
  input wire irq_enable, // software interrupt mask, 1 = allowed
  input wire irq_request, // external maskable interrupt
  output reg irq_taken_r, // vector valid pulse
  output reg [7:0] irq_vector_r, // captured vector
  input wire poll_start, // poll instruction start
  input wire poll_n, // poll pin
  input wire port1_line4_is_input, // port1 line4 mode
  output reg poll_busy_r, // poll still waiting
  output reg poll_done_r, // poll finished pulse
  input wire refresh_req, // refresh pulse from refresh unit
  input wire ready, // ready pin, low = wait
  input wire bus_hold_request, // outside master wants bus
  output reg bus_hold_grant_n, // hold granted, low
  output reg [10:0] addr_mux_o, // multiplexed lines: bits 9..17 or 1..8, plus 18/ube
  output reg addr_mux_oe, // enable for addr_mux_o
  output reg addr_a0_o, // address bit 0
  output reg addr_a19_o, // address bit 19
  output reg addr_fixed_oe, // enable for bits 0 and 19
  output reg [15:0] data_o, // data bus out
  output reg data_lo_oe, // enable low data byte
  output reg data_hi_oe, // enable high data byte
  input wire [15:0] data_i, // data bus in
  output reg memory_request_n, // memory request
  output reg memory_strobe_n, // memory strobe
  output reg io_strobe_n, // io strobe
  output reg read_write_o, // 1 read, 0 write
  output reg refresh_pulse_n, // refresh request out
  output reg ctrl_oe, // enable for request, strobes, read/write, refresh
  output reg irq_acknowledge_n, // interrupt acknowledge
  output wire system_clock_output // clock out
);
  reg [2:0] state_r;
  reg [1:0] wait_cnt_r;
  reg cyc_io_r, cyc_write_r, second_r, split_r;
  reg [19:0] cyc_addr_r;
  reg [15:0] cyc_wdata_r;
  reg ube_n_r;
  reg irq_pend_r;
  wire ready_s;

  assign system_clock_output = clk_sys;

  ready_sync u_ready (
    .clk_sys(clk_sys),
    .reset(reset),
    .ready_in(ready),
    .ready_sync_r(ready_s)
  );

  wire poll_busy_w, poll_done_w;
  poll_waiter u_poll (
    .clk_sys(clk_sys),
    .reset(reset),
    .poll_start(poll_start),
    .poll_n(poll_n),
    .port1_line4_is_input(port1_line4_is_input),
    .poll_busy_r(poll_busy_w),
    .poll_done_r(poll_done_w)
  );
  always @(posedge clk_sys) begin
    if (reset) begin
      poll_busy_r <= 1'b0;
      poll_done_r <= 1'b0;
    end else begin
      poll_busy_r <= poll_busy_w;
      poll_done_r <= poll_done_w;
    end
  end

  // row bits go on lines 0..8, line 9 spare, line 10 is bit 18 or byte enable
  function [10:0] row_lines;
    input [19:0] a;
    row_lines = {a[18], 1'b0, a[`ROW_HI:`ROW_LO]};
  endfunction
  function [10:0] col_lines;
    input [19:0] a;
    input ube_n;
    col_lines = {ube_n, 2'b00, a[8:1]};
  endfunction

  // byte lanes: an odd word goes low byte first at odd, then even of next
  wire odd_word = req_word & req_addr[0];
  wire req_ube_n = ~(req_word | req_addr[0]);

  always @(posedge clk_sys) begin
    if (reset) begin
      state_r <= `ST_IDLE;
      wait_cnt_r <= 2'h0;
      cyc_io_r <= 1'b0;
      cyc_write_r <= 1'b0;
      second_r <= 1'b0;
      split_r <= 1'b0;
      cyc_addr_r <= 20'h00000;
      cyc_wdata_r <= 16'h0000;
      ube_n_r <= 1'b1;
      irq_pend_r <= 1'b0;
      req_accept_r <= 1'b0;
      req_done_r <= 1'b0;
      req_rdata_r <= 16'h0000;
      irq_taken_r <= 1'b0;
      irq_vector_r <= 8'h00;
      bus_hold_grant_n <= 1'b1;
      addr_mux_o <= 11'h000;
      addr_mux_oe <= 1'b0;
      addr_a0_o <= 1'b0;
      addr_a19_o <= 1'b0;
      addr_fixed_oe <= 1'b0;
      data_o <= 16'h0000;
      data_lo_oe <= 1'b0;
      data_hi_oe <= 1'b0;
      memory_request_n <= 1'b1;
      memory_strobe_n <= 1'b1;
      io_strobe_n <= 1'b1;
      read_write_o <= 1'b1;
      refresh_pulse_n <= 1'b1;
      ctrl_oe <= 1'b0;
      irq_acknowledge_n <= 1'b1;
    end else begin
      req_accept_r <= 1'b0;
      req_done_r <= 1'b0;
      irq_taken_r <= 1'b0;
      refresh_pulse_n <= ~refresh_req;
      case (state_r)
        `ST_IDLE: begin
          memory_request_n <= 1'b1;
          memory_strobe_n <= 1'b1;
          io_strobe_n <= 1'b1;
          irq_acknowledge_n <= 1'b1;
          data_lo_oe <= 1'b0;
          data_hi_oe <= 1'b0;
          ctrl_oe <= 1'b1;
          addr_mux_oe <= 1'b1;
          addr_fixed_oe <= 1'b1;
          // second byte of a split word is its own bus cycle with a fresh request edge
          if (split_r && second_r) begin
            split_r <= 1'b0;
            addr_mux_o <= row_lines(cyc_addr_r);
            addr_a0_o <= cyc_addr_r[0];
            addr_a19_o <= cyc_addr_r[19];
            memory_request_n <= 1'b0;
            state_r <= `ST_ROW;
          end else if (bus_hold_request) begin
            state_r <= `ST_HOLD;
            bus_hold_grant_n <= 1'b0;
            ctrl_oe <= 1'b0;
            addr_mux_oe <= 1'b0;
            addr_fixed_oe <= 1'b0;
          end else if (irq_pend_r) begin
            irq_pend_r <= 1'b0;
            irq_acknowledge_n <= 1'b0;
            state_r <= `ST_INTA;
          end else if (req_valid) begin
            req_accept_r <= 1'b1;
            cyc_io_r <= req_io;
            cyc_write_r <= req_write;
            cyc_addr_r <= req_addr;
            cyc_wdata_r <= req_wdata;
            split_r <= odd_word;
            second_r <= 1'b0;
            ube_n_r <= req_ube_n;
            addr_mux_o <= row_lines(req_addr);
            addr_a0_o <= req_addr[0];
            addr_a19_o <= req_addr[19];
            memory_request_n <= 1'b0;
            read_write_o <= ~req_write;
            state_r <= `ST_ROW;
          end
        end
        `ST_ROW: begin
          addr_mux_o <= col_lines(cyc_addr_r, ube_n_r);
          wait_cnt_r <= 2'h0;
          if (cyc_io_r) begin
            io_strobe_n <= 1'b0;
          end else begin
            memory_strobe_n <= 1'b0;
          end
          if (cyc_write_r) begin
            data_o <= cyc_addr_r[0] ? {cyc_wdata_r[7:0], cyc_wdata_r[15:8]} : cyc_wdata_r;
            data_lo_oe <= 1'b1;
            data_hi_oe <= 1'b1;
          end
          state_r <= `ST_COL;
        end
        `ST_COL: begin
          if (!ready_s) begin
            wait_cnt_r <= 2'h0;
            state_r <= `ST_WAIT;
          end else begin
            state_r <= `ST_FINAL;
          end
        end
        `ST_WAIT: begin
          if (wait_cnt_r != `MIN_WAITS) begin
            wait_cnt_r <= wait_cnt_r + 2'h1;
          end
          if (ready_s && wait_cnt_r >= 2'h1) begin
            state_r <= `ST_FINAL;
          end
        end
        `ST_FINAL: begin
          memory_strobe_n <= 1'b1;
          io_strobe_n <= 1'b1;
          memory_request_n <= 1'b1;
          data_lo_oe <= 1'b0;
          data_hi_oe <= 1'b0;
          if (split_r && !second_r) begin
            req_rdata_r[7:0] <= data_i[15:8]; // odd byte rides the upper lane
            cyc_wdata_r <= {8'h00, cyc_wdata_r[15:8]};
            cyc_addr_r <= cyc_addr_r + 20'h00001;
            ube_n_r <= 1'b1;
            second_r <= 1'b1;
            state_r <= `ST_IDLE;
          end else begin
            if (second_r) begin
              req_rdata_r[15:8] <= data_i[7:0];
            end else if (cyc_addr_r[0]) begin
              req_rdata_r <= {8'h00, data_i[15:8]};
            end else begin
              req_rdata_r <= data_i;
            end
            req_done_r <= 1'b1;
            read_write_o <= 1'b1;
            state_r <= `ST_IDLE;
          end
        end
        `ST_INTA: begin
          irq_acknowledge_n <= 1'b1;
          irq_vector_r <= data_i[7:0];
          irq_taken_r <= 1'b1;
          state_r <= `ST_IDLE;
        end
        `ST_HOLD: begin
          if (!bus_hold_request) begin
            bus_hold_grant_n <= 1'b1;
            ctrl_oe <= 1'b1;
            addr_mux_oe <= 1'b1;
            addr_fixed_oe <= 1'b1;
            state_r <= `ST_IDLE;
          end
        end
        default: begin
          state_r <= `ST_IDLE;
        end
      endcase
      // after the case so a new request wins over the clear in the same cycle
      if (insn_last_cycle && irq_enable && irq_request) begin
        irq_pend_r <= 1'b1;
      end
    end
  end
endmodule

// ---- test/bus_interface_sva.sv ----
// port assertions for the bus sequencer
// assumes it is bound into multiplexed_dram_bus_interface
`timescale 1ns/1ps
module bus_interface_sva (
  input wire clk_sys, // clock
  input wire reset, // reset
  input wire ready, // wait in
  input wire bus_hold_request, // hold in
  input wire bus_hold_grant_n, // grant
  input wire addr_mux_oe, // oe
  input wire addr_fixed_oe, // oe
  input wire data_lo_oe, // oe
  input wire ctrl_oe, // oe
  input wire addr_a0_o, // bit 0
  input wire addr_a19_o, // bit 19
  input wire memory_request_n, // request
  input wire memory_strobe_n, // strobe
  input wire io_strobe_n, // io strobe
  input wire req_done_r, // done
  input wire irq_acknowledge_n, // ack
  input wire irq_taken_r // taken
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_strobe_in_req:
    assert property ((!memory_strobe_n || !io_strobe_n) |-> !memory_request_n)
    else $error("strobe outside request");
  a_req_then_strobe:
    assert property ($fell(memory_request_n) |=> (!memory_strobe_n || !io_strobe_n))
    else $error("no strobe after request");
  a_fixed_bits_stable:
    assert property ((!memory_request_n && !$past(memory_request_n))
      |-> $stable({addr_a19_o, addr_a0_o})) else $error("fixed address moved");
  a_hold_floats:
    assert property (!bus_hold_grant_n |-> !(addr_mux_oe || addr_fixed_oe || data_lo_oe || ctrl_oe))
    else $error("bus driven during hold");
  a_grant_release:
    assert property (!bus_hold_request [*3] |-> bus_hold_grant_n) else $error("grant kept");
  a_ready_stall:
    assert property (!ready [*6] |-> !req_done_r) else $error("done while not ready");
  a_ack_vector:
    assert property ($fell(irq_acknowledge_n) |=> irq_acknowledge_n ##[0:1] irq_taken_r)
    else $error("ack without vector");
  a_io_strobe_only:
    assert property (!io_strobe_n |-> memory_strobe_n) else $error("both strobes low");
endmodule
bind multiplexed_dram_bus_interface bus_interface_sva u_bus_interface_sva (.*);

// ---- test/bus_partner_model.sv ----
// far side: memory answering reads, interrupt controller giving a vector
// assumes the pins of the bus sequencer
`timescale 1ns/1ps
module bus_partner_model (
  input wire clk_sys, // clock
  input wire [10:0] addr_mux_o, // lines
  input wire memory_request_n, // request
  input wire memory_strobe_n, // strobe
  input wire read_write_o, // 1 read
  input wire irq_acknowledge_n, // ack
  input wire stall, // slow mode
  output wire [15:0] data_i, // data
  output wire ready // ready
);
  reg [15:0] junk_r = 16'h0;
  reg ack_d_r = 1'h0;
  always @(posedge clk_sys) begin
    junk_r <= junk_r + 16'h3b5d;
    ack_d_r <= ~irq_acknowledge_n;
  end
  // released bus keeps moving so stale data cannot pass
  assign data_i = (!memory_request_n && !memory_strobe_n && read_write_o) ?
    {8'h5a, addr_mux_o[7:0]} : (!irq_acknowledge_n || ack_d_r) ? {junk_r[15:8], 8'h3c} :
    junk_r;
  assign ready = ~stall;
endmodule

// ---- test/multiplexed_dram_bus_interface_tb_top.sv ----
// self-checking bench for the multiplexed bus sequencer
// assumes the partner model answers read and vector cycles
`timescale 1ns/1ps
module multiplexed_dram_bus_interface_tb_top;
  reg clk_sys = 1'h0, reset = 1'h1, req_valid = 1'h0, req_io = 1'h0, req_write = 1'h0;
  reg req_word = 1'h0, insn_last_cycle = 1'h0, irq_enable = 1'h0, irq_request = 1'h0;
  reg poll_start = 1'h0, poll_n = 1'h1, port1_line4_is_input = 1'h1, refresh_req = 1'h0;
  reg bus_hold_request = 1'h0, stall = 1'h0;
  reg [19:0] req_addr = 20'h0;
  reg [15:0] req_wdata = 16'h0;
  wire req_accept_r, req_done_r, irq_taken_r, poll_busy_r, poll_done_r, bus_hold_grant_n;
  wire [15:0] req_rdata_r, data_o, data_i;
  wire [7:0] irq_vector_r;
  wire [10:0] addr_mux_o;
  wire addr_mux_oe, addr_a0_o, addr_a19_o, addr_fixed_oe, data_lo_oe, data_hi_oe, ready;
  wire memory_request_n, memory_strobe_n, io_strobe_n, read_write_o, refresh_pulse_n;
  wire ctrl_oe, irq_acknowledge_n, system_clock_output;
  integer fails = 0, checks = 0, lat;
  reg [10:0] row, col;
  reg [8:0] dq;
  reg rw, ios, ms, a0, a19;
  always #20 clk_sys = ~clk_sys;
  multiplexed_dram_bus_interface u_multiplexed_dram_bus_interface (.*);
  bus_partner_model u_bus_partner_model (.clk_sys(clk_sys), .addr_mux_o(addr_mux_o),
    .memory_request_n(memory_request_n), .memory_strobe_n(memory_strobe_n), .stall(stall),
    .read_write_o(read_write_o), .irq_acknowledge_n(irq_acknowledge_n), .data_i(data_i),
    .ready(ready));
  task check(input string nm, input [19:0] seen, exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task access(input io, wr, wd, input [19:0] ad);
    begin
      @(negedge clk_sys);
      {req_valid, req_io, req_write, req_word, req_addr} = {1'h1, io, wr, wd, ad};
      req_wdata = {ad[7:0], 8'hc3};
      lat = 0;
      while (req_accept_r !== 1'h1 && lat < 20) begin
        @(negedge clk_sys);
        lat = lat + 1;
      end
      {row, rw, a0, a19} = {addr_mux_o, read_write_o, addr_a0_o, addr_a19_o};
      req_valid = 1'h0;
      @(negedge clk_sys);
      {col, ios, ms, dq} = {addr_mux_o, io_strobe_n, memory_strobe_n, data_hi_oe, data_o[15:8]};
      lat = 1;
      while (req_done_r !== 1'h1 && lat < 40) begin
        @(negedge clk_sys);
        lat = lat + 1;
      end
    end
  endtask
  task t_read(input [19:0] ad);
    begin
      access(1'h0, 1'h0, 1'h1, ad);
      check("row", {row[10], row[8:0]}, {ad[18], ad[17:9]});
      check("col", {col[10], col[7:0]}, {1'h0, ad[8:1]});
      check("fixed", {a19, a0, rw}, {ad[19], ad[0], 1'h1});
      check("cycle", lat[19:0], 20'h3);
      check("rdata", req_rdata_r, {8'h5a, ad[8:1]});
    end
  endtask
  task t_odd_word;
    begin
      access(1'h0, 1'h0, 1'h1, 20'h2_4a67);
      check("split", lat[19:0], 20'h7);
      check("ube", {a0, col[10]}, 2'h2);
      check("swap", req_rdata_r, 16'h345a);
    end
  endtask
  task t_write_io;
    begin
      access(1'h0, 1'h1, 1'h0, 20'h3_0011);
      check("write", {rw, ms, dq}, {2'h0, 9'h1c3});
      access(1'h1, 1'h0, 1'h0, 20'h0_1234);
      check("io", {ios, ms, col[7:0]}, {2'h1, 8'h1a});
    end
  endtask
  task t_ready;
    begin
      stall = 1'h1;
      fork
        access(1'h0, 1'h0, 1'h1, 20'h0_0010);
        begin
          repeat (8) @(negedge clk_sys);
          stall = 1'h0;
        end
      join
      check("wait", lat >= 5, 1'h1);
    end
  endtask
  task t_hold;
    begin
      bus_hold_request = 1'h1;
      repeat (4) @(negedge clk_sys);
      check("hold", {bus_hold_grant_n, addr_mux_oe, addr_fixed_oe, data_lo_oe, ctrl_oe}, 5'h0);
      bus_hold_request = 1'h0;
      repeat (4) @(negedge clk_sys);
      check("release", bus_hold_grant_n, 1'h1);
    end
  endtask
  task t_irq;
    begin
      {irq_request, insn_last_cycle} = 2'h3;
      for (lat = 0; lat < 6; lat = lat + 1) begin
        @(negedge clk_sys);
        if (lat == 2) {irq_enable, insn_last_cycle} = 2'h2;
        check("masked", irq_acknowledge_n, 1'h1);
      end
      insn_last_cycle = 1'h1;
      lat = 0;
      while (irq_acknowledge_n !== 1'h0 && lat < 10) begin
        @(negedge clk_sys);
        insn_last_cycle = 1'h0;
        lat = lat + 1;
      end
      check("ack", irq_acknowledge_n, 1'h0);
      irq_request = 1'h0;
      @(negedge clk_sys);
      check("vector", {irq_taken_r, irq_vector_r}, 9'h13c);
    end
  endtask
  task t_poll(input pn, l4, input integer lo_at, minl, maxl);
    begin
      {poll_n, port1_line4_is_input, poll_start} = {pn, l4, 1'h1};
      @(negedge clk_sys);
      poll_start = 1'h0;
      lat = 0;
      while (poll_done_r !== 1'h1 && lat < 40) begin
        @(negedge clk_sys);
        lat = lat + 1;
        if (lat == lo_at) poll_n = 1'h0;
      end
      check("poll", lat >= minl && lat <= maxl, 1'h1);
      @(negedge clk_sys);
    end
  endtask
  initial begin
    #120000;
    fails = fails + 1;
    final_report;
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    reset = 1'h0;
    check("idle", {memory_request_n, memory_strobe_n, io_strobe_n, irq_acknowledge_n}, 4'hf);
    check("system_clock_output", system_clock_output, 1'h0);
    t_read(20'h5_a2b4);
    t_read(20'hf_fffe);
    t_odd_word;
    t_write_io;
    t_ready;
    t_hold;
    t_poll(1'h0, 1'h1, 99, 0, 3);
    t_poll(1'h1, 1'h1, 10, 10, 18);
    t_poll(1'h1, 1'h0, 99, 0, 3);
    t_irq;
    final_report;
  end
endmodule
